// >>> rtl/eep_prog_ctrl.sv
// Serial EEPROM program/erase control: instruction capture, latch, self-timed cycle
// How it works
// - Single write starts a timed clear-then-store of the word at select fall.
// - Timed cycle runs from the core clock, needing no serial clock pulses.
// - Host may raise select during or after a cycle and read status on data-out.
// - Single write clears the word itself; no separate clear needed.
// - Single clear starts a timed clear of only the addressed word at select fall.
// - A cleared word reads back all ones.
// - Program-enable latch is cleared at power-up, blocking all program instructions.
// - Latch stays set until power loss or a disable-programming instruction.
// - With latch cleared, write and clear instructions are ignored, array unchanged.
// - Reads work regardless of the latch.
// - Clear-all starts a timed clear of every location at select fall.
// - After clear-all every array bit reads one.
// - Write-all starts a timed write of its word into every location at select fall.
// - Write-all gives correct contents without a prior clear-all.
// - With select high, data-out is low while busy and high when ready.
// - Program instructions need the enable pin high; enable and disable ignore it.
// - Instruction is start bit, opcode, address, then data for writes.
// - Data-in bits are sampled on the rising serial clock edge.
`timescale 1ns/10ps
`include "eep_consts.svh"
module eep_prog_ctrl #(
	parameter int AW          = `EEP_ADDR_W,
	parameter int PROG_CYCLES = `EEP_EW_CYCLES
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          ser_clk,
	input  wire logic          chip_sel,
	input  wire logic          ser_din,
	input  wire logic          program_enable_pin,
	input  wire logic          word_width_select_pin,
	input  wire logic [AW:0]   rd_addr,
	output logic               ser_dout,
	output logic               ser_dout_oe,
	output logic               busy,
	output logic               latch_enabled,
	output logic [7:0]         rd_data
);
	localparam int SR_W = `EEP_OP_BITS + AW + 1 + `EEP_DATA_W;
	localparam int CW   = $clog2(SR_W + 1);
	localparam int TW   = $clog2(PROG_CYCLES + 1);
	localparam int NB   = 2 ** (AW + 1);

	generate
		if (AW < 3 || AW > 14 || PROG_CYCLES < 1) begin : g_bad_param
			$error("eep_prog_ctrl: unsupported AW or PROG_CYCLES");
		end
	endgenerate

	// Serial clock domain. Frame state is cleared by select low, since the
	// serial clock may stand still between frames.
	logic             frame_rstn;
	logic             org_sk;
	logic             started_q, started_d;
	logic             done_q, done_d;
	logic             need_data_q, need_data_d;
	logic [CW-1:0]    cnt_q, cnt_d;
	logic [SR_W-1:0]  sr_q, sr_d;
	logic [1:0]       op_s_q, op_s_d;
	logic [AW:0]      addr_s_q, addr_s_d;
	logic [1:0]       hold_op_q, hold_op_d;
	logic [AW:0]      hold_addr_q, hold_addr_d;
	logic [15:0]      hold_data_q, hold_data_d;
	logic             tgl_q, tgl_d;

	assign frame_rstn = rstn & chip_sel;

	logic             org_q;
	eep_sync2 #(.WIDTH(1)) u_org_sk (
		.clk  (ser_clk),
		.rstn (rstn),
		.din  (org_q),
		.dout (org_sk)
	);

	always_comb begin
		logic [SR_W-1:0] sh;
		logic [CW-1:0]   inc;
		logic [CW-1:0]   alen;
		logic [CW-1:0]   dlen;
		logic [1:0]      op_now;
		logic [AW:0]     addr_now;
		logic [1:0]      sub_now;
		logic            wants;
		sh          = {sr_q[SR_W-2:0], ser_din};
		inc         = cnt_q + CW'(1);
		alen        = org_sk ? CW'(AW) : CW'(AW + 1);
		dlen        = org_sk ? CW'(`EEP_DLEN_X16) : CW'(`EEP_DLEN_X8);
		op_now      = org_sk ? sh[AW+1:AW] : sh[AW+2:AW+1];
		addr_now    = org_sk ? {1'b0, sh[AW-1:0]} : sh[AW:0];
		sub_now     = org_sk ? addr_now[AW-1:AW-2] : addr_now[AW:AW-1];
		wants       = (op_now == `EEP_OP_WRITE) ||
		              (op_now == `EEP_OP_MISC && sub_now == `EEP_SUB_WRITE_ALL_INSTR);
		started_d   = started_q;
		done_d      = done_q;
		need_data_d = need_data_q;
		cnt_d       = cnt_q;
		sr_d        = sr_q;
		op_s_d      = op_s_q;
		addr_s_d    = addr_s_q;
		hold_op_d   = hold_op_q;
		hold_addr_d = hold_addr_q;
		hold_data_d = hold_data_q;
		tgl_d       = tgl_q;
		if (!started_q) begin
			// Leading zeros are idle; the first one is the start bit
			started_d = ser_din;
		end else if (!done_q) begin
			sr_d  = sh;
			cnt_d = inc;
			if (inc == CW'(`EEP_OP_BITS) + alen) begin
				op_s_d      = op_now;
				addr_s_d    = addr_now;
				need_data_d = wants;
				if (!wants) begin
					done_d      = 1'b1;
					hold_op_d   = op_now;
					hold_addr_d = addr_now;
					tgl_d       = ~tgl_q;
				end
			end else if (need_data_q && inc == CW'(`EEP_OP_BITS) + alen + dlen) begin
				done_d      = 1'b1;
				hold_op_d   = op_s_q;
				hold_addr_d = addr_s_q;
				hold_data_d = sh[15:0];
				tgl_d       = ~tgl_q;
			end
		end
	end

	always_ff @(posedge ser_clk or negedge frame_rstn) begin
		if (!frame_rstn) begin
			started_q   <= 1'b0;
			done_q      <= 1'b0;
			need_data_q <= 1'b0;
			cnt_q       <= '0;
			sr_q        <= '0;
			op_s_q      <= 2'h0;
			addr_s_q    <= '0;
		end else begin
			started_q   <= started_d;
			done_q      <= done_d;
			need_data_q <= need_data_d;
			cnt_q       <= cnt_d;
			sr_q        <= sr_d;
			op_s_q      <= op_s_d;
			addr_s_q    <= addr_s_d;
		end
	end

	// Completed instruction, stable until the next frame completes
	always_ff @(posedge ser_clk or negedge rstn) begin
		if (!rstn) begin
			hold_op_q   <= 2'h0;
			hold_addr_q <= '0;
			hold_data_q <= 16'h0000;
			tgl_q       <= 1'b0;
		end else begin
			hold_op_q   <= hold_op_d;
			hold_addr_q <= hold_addr_d;
			hold_data_q <= hold_data_d;
			tgl_q       <= tgl_d;
		end
	end

	// Core clock domain
	logic [3:0]           s;
	logic                 cs_s, tgl_s, pe_s, org_s;
	eep_sync2 #(.WIDTH(4)) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  ({chip_sel, tgl_q, program_enable_pin, word_width_select_pin}),
		.dout (s)
	);
	assign {cs_s, tgl_s, pe_s, org_s} = s;

	eep_pkg::eep_state_e  state_q, state_d;
	eep_pkg::eep_kind_e   kind_q, kind_d;
	logic                 org_d;
	logic                 cs_prev_q, cs_prev_d;
	logic                 tgl_prev_q, tgl_prev_d;
	logic                 pend_q, pend_d;
	logic [1:0]           p_op_q, p_op_d;
	logic [AW:0]          p_addr_q, p_addr_d;
	logic [15:0]          p_data_q, p_data_d;
	logic [AW:0]          x_addr_q, x_addr_d;
	logic [15:0]          x_data_q, x_data_d;
	logic                 x_org_q, x_org_d;
	logic                 latch_q, latch_d;
	logic                 armed_q, armed_d;
	logic [TW-1:0]        timer_q, timer_d;
	logic                 commit;
	logic                 dout_q, dout_d;
	logic                 dout_oe_q, dout_oe_d;
	logic                 busy_q, busy_d;
	logic [7:0]           rd_data_q, rd_data_d;
	logic [7:0]           mem_q [NB];

	always_comb begin
		logic        tgl_edge;
		logic        cs_fall;
		logic        start;
		logic [1:0]  c_op;
		logic [AW:0] c_addr;
		logic [15:0] c_data;
		logic [1:0]  sub;
		tgl_edge   = tgl_s ^ tgl_prev_q;
		cs_fall    = cs_prev_q & ~cs_s;
		// A frame may finish in the same cycle its select fall is seen
		c_op       = tgl_edge ? hold_op_q : p_op_q;
		c_addr     = tgl_edge ? hold_addr_q : p_addr_q;
		c_data     = tgl_edge ? hold_data_q : p_data_q;
		sub        = org_q ? c_addr[AW-1:AW-2] : c_addr[AW:AW-1];
		start      = 1'b0;
		org_d      = org_s;
		cs_prev_d  = cs_s;
		tgl_prev_d = tgl_s;
		pend_d     = pend_q | tgl_edge;
		p_op_d     = c_op;
		p_addr_d   = c_addr;
		p_data_d   = c_data;
		state_d    = state_q;
		kind_d     = kind_q;
		x_addr_d   = x_addr_q;
		x_data_d   = x_data_q;
		x_org_d    = x_org_q;
		latch_d    = latch_q;
		armed_d    = armed_q;
		timer_d    = timer_q;
		commit     = 1'b0;
		case (state_q)
			eep_pkg::EEP_ST_IDLE: begin
				if (cs_fall && (pend_q || tgl_edge)) begin
					pend_d = 1'b0;
					case (c_op)
						`EEP_OP_WRITE: begin
							start  = 1'b1;
							kind_d = eep_pkg::EEP_K_WRITE;
						end
						`EEP_OP_ERASE: begin
							start  = 1'b1;
							kind_d = eep_pkg::EEP_K_ERASE;
						end
						`EEP_OP_MISC: begin
							if (sub == `EEP_SUB_EN) begin
								latch_d = 1'b1;
							end else if (sub == `EEP_SUB_DIS) begin
								latch_d = 1'b0;
							end else if (sub == `EEP_SUB_CLEAR_ALL_INSTR) begin
								start  = 1'b1;
								kind_d = eep_pkg::EEP_K_CLEAR_ALL_INSTR;
							end else begin
								start  = 1'b1;
								kind_d = eep_pkg::EEP_K_WRITE_ALL_INSTR;
							end
						end
						default: start = 1'b0;
					endcase
					// Blocked starts leave the array untouched
					if (start && latch_q && pe_s) begin
						state_d  = eep_pkg::EEP_ST_BUSY;
						x_addr_d = c_addr;
						x_data_d = c_data;
						x_org_d  = org_q;
						timer_d  = TW'(PROG_CYCLES - 1);
						armed_d  = 1'b1;
					end else begin
						armed_d = 1'b0;
					end
				end else if (cs_fall) begin
					armed_d = 1'b0;
				end
			end
			eep_pkg::EEP_ST_BUSY: begin
				// Commands arriving now are dropped at their select fall
				if (cs_fall) begin
					pend_d = 1'b0;
				end
				// Runs on the core clock alone
				if (timer_q == '0) begin
					commit  = 1'b1;
					state_d = eep_pkg::EEP_ST_IDLE;
				end else begin
					timer_d = timer_q - TW'(1);
				end
			end
			default: state_d = eep_pkg::EEP_ST_IDLE;
		endcase
		dout_oe_d = cs_s & armed_d;
		dout_d    = (state_d == eep_pkg::EEP_ST_IDLE);
		busy_d    = (state_d == eep_pkg::EEP_ST_BUSY);
		rd_data_d = mem_q[rd_addr];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q    <= eep_pkg::EEP_ST_IDLE;
			kind_q     <= eep_pkg::EEP_K_WRITE;
			org_q      <= 1'b0;
			cs_prev_q  <= 1'b0;
			tgl_prev_q <= 1'b0;
			pend_q     <= 1'b0;
			p_op_q     <= 2'h0;
			p_addr_q   <= '0;
			p_data_q   <= 16'h0000;
			x_addr_q   <= '0;
			x_data_q   <= 16'h0000;
			x_org_q    <= 1'b0;
			latch_q    <= 1'b0;
			armed_q    <= 1'b0;
			timer_q    <= '0;
			dout_q     <= 1'b1;
			dout_oe_q  <= 1'b0;
			busy_q     <= 1'b0;
			rd_data_q  <= 8'h00;
		end else begin
			state_q    <= state_d;
			kind_q     <= kind_d;
			org_q      <= org_d;
			cs_prev_q  <= cs_prev_d;
			tgl_prev_q <= tgl_prev_d;
			pend_q     <= pend_d;
			p_op_q     <= p_op_d;
			p_addr_q   <= p_addr_d;
			p_data_q   <= p_data_d;
			x_addr_q   <= x_addr_d;
			x_data_q   <= x_data_d;
			x_org_q    <= x_org_d;
			latch_q    <= latch_d;
			armed_q    <= armed_d;
			timer_q    <= timer_d;
			dout_q     <= dout_d;
			dout_oe_q  <= dout_oe_d;
			busy_q     <= busy_d;
			rd_data_q  <= rd_data_d;
		end
	end

	// Array as bytes; a 16-bit word occupies bytes 2a (low) and 2a+1 (high)
	for (genvar i = 0; i < NB; i++) begin : g_mem
		logic [7:0] d;
		always_comb begin
			logic       hit;
			logic [7:0] half;
			hit  = x_org_q ? (x_addr_q[AW-1:0] == AW'(i / 2)) : (x_addr_q == (AW + 1)'(i));
			half = (x_org_q && (i % 2 == 1)) ? x_data_q[15:8] : x_data_q[7:0];
			d    = mem_q[i];
			if (commit) begin
				case (kind_q)
					// Whole word replaced, so no separate clear is needed
					eep_pkg::EEP_K_WRITE: if (hit) d = half;
					eep_pkg::EEP_K_ERASE: if (hit) d = `EEP_ERASED_BYTE;
					eep_pkg::EEP_K_CLEAR_ALL_INSTR:  d = `EEP_ERASED_BYTE;
					default:              d = half;
				endcase
			end
		end
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				mem_q[i] <= `EEP_ERASED_BYTE;
			end else begin
				mem_q[i] <= d;
			end
		end
	end

	assign ser_dout      = dout_q;
	assign ser_dout_oe   = dout_oe_q;
	assign busy          = busy_q;
	assign latch_enabled = latch_q;
	assign rd_data       = rd_data_q;
endmodule

// >>> include/eep_consts.svh
// Constants for the serial EEPROM program/erase control
`ifndef EEP_CONSTS_SVH
`define EEP_CONSTS_SVH

// Opcodes following the start bit
`define EEP_OP_MISC      2'h0
`define EEP_OP_WRITE     2'h1
`define EEP_OP_READ      2'h2
`define EEP_OP_ERASE     2'h3

// Sub-commands in the two top address bits of the misc opcode
`define EEP_SUB_DIS      2'h0
`define EEP_SUB_WRITE_ALL_INSTR     2'h1
`define EEP_SUB_CLEAR_ALL_INSTR     2'h2
`define EEP_SUB_EN       2'h3

`define EEP_OP_BITS      2
`define EEP_DLEN_X16     16
`define EEP_DLEN_X8      8
`define EEP_DATA_W       16
`define EEP_ADDR_W       10
`define EEP_ERASED_BYTE  8'hff

// Timing: times in ns as printed, cycle counts derived from the clock period
`define EEP_CLK_PERIOD_NS 25
`define EEP_EW_TIME_NS    5000000
`define EEP_EW_CYCLES     (`EEP_EW_TIME_NS / `EEP_CLK_PERIOD_NS)
`define EEP_CSMIN_NS      1000

`endif

// >>> include/eep_pkg.sv
// Types for the serial EEPROM program/erase control
package eep_pkg;

	typedef enum logic [1:0] {
		EEP_ST_IDLE = 2'h0,
		EEP_ST_BUSY = 2'h1
	} eep_state_e;

	typedef enum logic [1:0] {
		EEP_K_WRITE = 2'h0,
		EEP_K_ERASE = 2'h1,
		EEP_K_CLEAR_ALL_INSTR  = 2'h2,
		EEP_K_WRITE_ALL_INSTR  = 2'h3
	} eep_kind_e;

endpackage

// >>> rtl/eep_sync2.sv
// Two-flop level synchroniser
`timescale 1ns/10ps
module eep_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] out_d;

	always_comb begin
		meta_d = din;
		out_d  = meta_q;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '0;
			out_q  <= '0;
		end else begin
			meta_q <= meta_d;
			out_q  <= out_d;
		end
	end

	assign dout = out_q;
endmodule

// >>> tb/eep_host.sv
// Host model driving the three-wire link
`timescale 1ns/10ps
module eep_host (
	output logic ser_clk,
	output logic chip_sel,
	output logic ser_din
);
	initial begin
		ser_clk = 1'b0;
		chip_sel = 1'b0;
		ser_din = 1'b0;
	end
	// Serial clock stands low between frames
	task automatic send(input logic [31:0] bits, input int n);
		chip_sel = 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			ser_din = bits[i];
			#8 ser_clk = 1'b1;
			#16 ser_clk = 1'b0;
			#8;
		end
		// Released line shows the inverse, not a stale value
		ser_din = ~ser_din;
		sel(1'b0);
	endtask
	task automatic sel(input logic v);
		chip_sel = v;
		#1000;
	endtask
endmodule

// >>> tb/eep_prog_ctrl_chk.sv
// Port checker for the program/erase control
`timescale 1ns/10ps
module eep_prog_ctrl_chk #(
	parameter int PROG_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic chip_sel,
	input wire logic ser_dout,
	input wire logic ser_dout_oe,
	input wire logic busy,
	input wire logic latch_enabled
);
	int cnt_q;
	int cnt_d;
	always_comb cnt_d = busy ? cnt_q + 1 : 0;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			cnt_q <= 0;
		else
			cnt_q <= cnt_d;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Timer loads PROG_CYCLES-1 and commits at zero, so busy stands PROG_CYCLES cycles
	busy_len_a: assert property ($fell(busy) |-> cnt_q == PROG_CYCLES)
		else $error("busy length wrong");
	status_dout_a: assert property (ser_dout == !busy)
		else $error("status does not follow busy");
	start_cause_a: assert property ($rose(busy) |-> !$past(chip_sel, 3) && $past(latch_enabled))
		else $error("cycle started without cause");
	busy_hold_a: assert property ($rose(busy) |-> busy [*8])
		else $error("cycle stopped early");
	oe_sel_a: assert property ($rose(ser_dout_oe) |-> $past(chip_sel, 3))
		else $error("status driven while deselected");
	latch_drop_a: assert property ($fell(latch_enabled) |-> !$past(chip_sel, 3))
		else $error("latch cleared without instruction");
	latch_busy_a: assert property (busy && $past(busy) |-> $stable(latch_enabled))
		else $error("latch changed during cycle");
	oe_drop_a: assert property ($fell(chip_sel) && !busy |-> ##[1:6] !ser_dout_oe)
		else $error("status drive not released");
	cover property ($rose(busy));
	cover property ($rose(ser_dout_oe));
	cover property ($fell(latch_enabled));
endmodule

// >>> tb/eep_prog_ctrl_bench.sv
// Bench for the program/erase control with a byte-array model
`timescale 1ns/10ps
`include "eep_consts.svh"
module eep_prog_ctrl_bench;
	localparam int PC = 200;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        pe = 1'b1;
	logic        w16 = 1'b1;
	logic [10:0] rd_addr = 11'h000;
	logic        sck;
	logic        cs;
	logic        sdi;
	logic        ser_dout;
	logic        ser_dout_oe;
	logic        busy;
	logic        latch_enabled;
	logic [7:0]  rd_data;
	int          errors = 0;
	int          check_count = 0;
	int          em[2048];
	logic        lm = 1'b0;
	always #12.5 clk = ~clk;
	eep_host host_u (.ser_clk(sck), .chip_sel(cs), .ser_din(sdi));
	eep_prog_ctrl #(.PROG_CYCLES(PC)) dut_u (.clk(clk), .rstn(rstn), .ser_clk(sck),
		.chip_sel(cs), .ser_din(sdi), .program_enable_pin(pe), .word_width_select_pin(w16),
		.rd_addr(rd_addr), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe), .busy(busy),
		.latch_enabled(latch_enabled), .rd_data(rd_data));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_flag(input string nm, input logic e, input logic g);
		chk(nm, {7'h00, e}, {7'h00, g});
	endtask
	task automatic chk_mem();
		for (int a = 0; a < 2048; a++) begin
			@(posedge clk);
			rd_addr <= 11'(a);
			@(posedge clk);
			@(negedge clk);
			chk("rd_data", 8'(em[a]), rd_data);
		end
	endtask
	task automatic poll();
		int n;
		host_u.sel(1'b1);
		n = 0;
		chk_flag("oe", 1'b1, ser_dout_oe);
		chk_flag("status_busy", 1'b0, ser_dout);
		while (ser_dout !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk_flag("status_ready", 1'b1, ser_dout);
		host_u.sel(1'b0);
	endtask
	task automatic setp(input logic p, input logic w);
		@(posedge clk);
		pe <= p;
		w16 <= w;
		@(posedge clk);
	endtask
	task automatic go(input logic [1:0] op, input logic [1:0] sub, input int a,
		input logic [15:0] d, input bit np);
		logic [31:0] f;
		int n;
		bit hd;
		bit st;
		bit ms;
		ms = op == `EEP_OP_MISC;
		hd = op == `EEP_OP_WRITE || (ms && sub == `EEP_SUB_WRITE_ALL_INSTR);
		if (ms)
			a = 32'({sub, 9'h000}) >> w16;
		f = w16 ? {3'h0, 1'b1, op, a[9:0], d} : {10'h000, 1'b1, op, a[10:0], d[7:0]};
		n = w16 ? 29 : 22;
		if (!hd) begin
			f = f >> (w16 ? 16 : 8);
			n = n - (w16 ? 16 : 8);
		end
		host_u.send(f, n);
		st = lm && pe && (!ms || sub[1] != sub[0]);
		if (ms && sub == `EEP_SUB_EN)
			lm = 1'b1;
		if (ms && sub == `EEP_SUB_DIS)
			lm = 1'b0;
		for (int b = 0; b < 2048; b++) begin
			if (st && (ms || (w16 ? b / 2 == a : b == a)))
				em[b] = (op == `EEP_OP_ERASE || (ms && sub == `EEP_SUB_CLEAR_ALL_INSTR)) ? 255 :
					(w16 && b[0] ? d[15:8] : d[7:0]);
		end
		if (np)
			return;
		if (st)
			poll();
		else
			chk_flag("busy", 1'b0, busy);
		chk_flag("latch", lm, latch_enabled);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		int a;
		logic [15:0] d;
		foreach (em[i])
			em[i] = 255;
		void'($urandom(54947));
		a = $urandom_range(1023);
		d = 16'($urandom);
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk_flag("ready", 1'b1, ser_dout);
		chk_flag("latch", 1'b0, latch_enabled);
		go(`EEP_OP_WRITE, 2'h0, a, d, 0);
		chk_mem();
		$display("test reset done");
		go(`EEP_OP_MISC, `EEP_SUB_EN, 0, 16'h0000, 0);
		go(`EEP_OP_WRITE, 2'h0, a, d, 0);
		go(`EEP_OP_WRITE, 2'h0, a, ~d, 0);
		chk_mem();
		go(`EEP_OP_WRITE, 2'h0, a ^ 1, d, 1);
		host_u.send(32'h0000_1000, 13);
		poll();
		chk_flag("latch", 1'b1, latch_enabled);
		go(`EEP_OP_ERASE, 2'h0, a, 16'h0000, 0);
		chk_mem();
		$display("test word done");
		setp(1'b0, 1'b1);
		go(`EEP_OP_WRITE, 2'h0, a, d, 0);
		go(`EEP_OP_MISC, `EEP_SUB_DIS, 0, 16'h0000, 0);
		go(`EEP_OP_MISC, `EEP_SUB_EN, 0, 16'h0000, 0);
		setp(1'b1, 1'b1);
		go(`EEP_OP_MISC, `EEP_SUB_WRITE_ALL_INSTR, 0, d, 0);
		chk_mem();
		go(`EEP_OP_MISC, `EEP_SUB_CLEAR_ALL_INSTR, 0, 16'h0000, 0);
		chk_mem();
		$display("test all done");
		setp(1'b1, 1'b0);
		go(`EEP_OP_WRITE, 2'h0, $urandom_range(2047), d, 0);
		go(`EEP_OP_MISC, `EEP_SUB_DIS, 0, 16'h0000, 0);
		chk_mem();
		$display("test byte done");
		results();
	end
	initial begin
		#2_000_000;
		errors++;
		results();
	end
endmodule
bind eep_prog_ctrl eep_prog_ctrl_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.clk(clk),
	.rstn(rstn), .chip_sel(chip_sel), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe),
	.busy(busy), .latch_enabled(latch_enabled));
